/* rtl/arith_pkg.sv */
// constants and types shared by the arithmetic symbol coder
package arith_pkg;
    // -------------------------------------------------------------
    // interval thresholds and initial values
    // -------------------------------------------------------------
    localparam logic [15:0] QUARTER_POINT       = 16'h4000;
    localparam logic [15:0] HALF_POINT          = 16'h8000;
    localparam logic [15:0] THREE_QUARTER_POINT = 16'hC000;
    localparam logic [15:0] TOP_VALUE           = 16'hFFFF;
    localparam logic [15:0] LOW_RESET           = 16'h0000;
    localparam logic [15:0] PENDING_RESET       = 16'h0000;
    localparam logic [15:0] CODE_RESET          = 16'h0000;

    // -------------------------------------------------------------
    // counts of cycles and bits
    // -------------------------------------------------------------
    localparam logic [4:0]  INIT_BITS           = 5'h10;
    localparam logic [5:0]  DIV_COUNT           = 6'h21;

    // -------------------------------------------------------------
    // commands from the syntax layer
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_ENC_START,
        CMD_ENC_SYMBOL,
        CMD_ENC_FLUSH,
        CMD_DEC_INIT,
        CMD_DEC_SYMBOL
    } cmd_t;

    // renormalisation cases
    typedef enum logic [1:0] {
        NORM_NONE,
        NORM_BELOW,
        NORM_ABOVE,
        NORM_MIDDLE
    } norm_t;

    // sequencer states
    typedef enum logic [3:0] {
        S_IDLE,
        S_RD_TOTAL,
        S_RD_HI,
        S_RD_LO,
        S_DEC_CUM,
        S_DEC_SEARCH,
        S_DIV_HI,
        S_DIV_LO,
        S_ENC_NORM,
        S_EMIT_WAIT,
        S_DEC_NORM,
        S_DEC_BIT,
        S_DEC_FILL
    } state_t;
endpackage

/* rtl/seq_divider.sv */
// serial restoring divider, one quotient bit per cycle
`timescale 1ns/1ns
module seq_divider
    import arith_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,
    input  wire logic [32:0] dividend_i,
    input  wire logic [16:0] divisor_i,
    output logic      [32:0] quot_o,
    output logic             done_o
);
    logic [32:0] quot_ff;
    logic [16:0] rem_ff;
    logic [16:0] div_ff;
    logic [5:0]  cnt_ff;
    logic        done_ff;
    logic [17:0] trial;

    // -------------------------------------------------------------
    // shift in one dividend bit per step
    // -------------------------------------------------------------
    assign trial = {rem_ff, quot_ff[32]};

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            quot_ff <= 33'h0;
            rem_ff  <= 17'h0;
            div_ff  <= 17'h0;
            cnt_ff  <= 6'h0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (start_i) begin
                quot_ff <= dividend_i;
                rem_ff  <= 17'h0;
                div_ff  <= divisor_i;
                cnt_ff  <= DIV_COUNT;
            end else if (cnt_ff != 6'h0) begin
                cnt_ff  <= cnt_ff - 6'h1;
                done_ff <= (cnt_ff == 6'h1);
                if (trial >= {1'b0, div_ff}) begin
                    rem_ff  <= 17'(trial - {1'b0, div_ff});
                    quot_ff <= {quot_ff[31:0], 1'b1};
                end else begin
                    rem_ff  <= trial[16:0];
                    quot_ff <= {quot_ff[31:0], 1'b0};
                end
            end
        end
    end

    assign quot_o = quot_ff;
    assign done_o = done_ff;
endmodule

/* rtl/bit_run_emitter.sv */
// sends one bit then a run of its opposite to the coded-bit fifo
`timescale 1ns/1ns
module bit_run_emitter (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,
    input  wire logic        first_bit_i,
    input  wire logic [15:0] count_i,
    input  wire logic        ready_i,
    output logic             bit_o,
    output logic             valid_o,
    output logic             done_o
);
    logic        bit_ff;
    logic        valid_ff;
    logic        first_ff;
    logic        done_ff;
    logic [15:0] left_ff;

    // -------------------------------------------------------------
    // bit holds until the fifo takes it
    // -------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_ff   <= 1'b0;
            valid_ff <= 1'b0;
            first_ff <= 1'b0;
            done_ff  <= 1'b0;
            left_ff  <= 16'h0;
        end else begin
            done_ff <= 1'b0;
            if (start_i) begin
                bit_ff   <= first_bit_i;
                first_ff <= first_bit_i;
                left_ff  <= count_i;
                valid_ff <= 1'b1;
            end else if (valid_ff && ready_i) begin
                if (left_ff == 16'h0) begin
                    valid_ff <= 1'b0;
                    done_ff  <= 1'b1;
                end else begin
                    bit_ff  <= ~first_ff;
                    left_ff <= left_ff - 16'h1;
                end
            end
        end
    end

    assign bit_o   = bit_ff;
    assign valid_o = valid_ff;
    assign done_o  = done_ff;
endmodule

/* rtl/arith_symbol_coder.sv */
// arithmetic symbol encoder and decoder with model and bit ports
`timescale 1ns/1ns
module arith_symbol_coder
    import arith_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        syntax_arith_coding_mode_i,
    input  wire logic        cmd_valid_i,
    input  wire cmd_t        cmd_i,
    input  wire logic [7:0]  index_i,
    output logic      [7:0]  model_addr_o,
    input  wire logic [15:0] model_data_i,
    output logic             enc_bit_o,
    output logic             enc_bit_valid_o,
    input  wire logic        enc_bit_ready_i,
    input  wire logic        dec_bit_i,
    input  wire logic        dec_bit_valid_i,
    output logic             dec_bit_ready_o,
    output logic      [7:0]  dec_index_o,
    output logic             busy_o,
    output logic             done_o
);
    state_t      state_ff;
    state_t      nxt_state;
    logic [15:0] low_ff;
    logic [15:0] high_ff;
    logic [15:0] code_ff;
    logic [15:0] pending_ff;
    logic [16:0] span_ff;
    logic [15:0] total_ff;
    logic [15:0] f_hi_ff;
    logic [15:0] f_lo_ff;
    logic [15:0] prev_ff;
    logic [15:0] cum_ff;
    logic [7:0]  idx_ff;
    logic [7:0]  addr_ff;
    logic [7:0]  dec_index_ff;
    logic [4:0]  fill_ff;
    logic        is_dec_ff;
    logic        flush_ff;
    logic        busy_ff;
    logic        done_ff;
    logic        ready_ff;
    logic        div_start_ff;
    logic        emit_start_ff;
    logic        emit_first_ff;
    logic [15:0] emit_cnt_ff;
    logic        accept;
    logic        take;
    logic        div_done;
    logic        emit_done;
    logic [32:0] quot;
    logic [32:0] dividend;
    logic [16:0] divisor;
    logic [15:0] mul_f;
    logic [16:0] offset;
    norm_t       ncase;
    logic [15:0] sub;

    // -------------------------------------------------------------
    // renormalisation helpers
    // -------------------------------------------------------------
    function automatic norm_t norm_case(input logic [15:0] lo, input logic [15:0] hi);
        if (hi < HALF_POINT)
            return NORM_BELOW;
        else if (lo >= HALF_POINT)
            return NORM_ABOVE;
        else if (lo >= QUARTER_POINT && hi < THREE_QUARTER_POINT)
            return NORM_MIDDLE;
        else
            return NORM_NONE;
    endfunction

    function automatic logic [15:0] sub_shl(input logic [15:0] v, input logic [15:0] s);
        logic [15:0] d;
        d = v - s;
        return {d[14:0], 1'b0};
    endfunction

    // commands only while idle and the mode is on
    assign accept    = (state_ff == S_IDLE) && cmd_valid_i && syntax_arith_coding_mode_i;
    assign take      = ready_ff && dec_bit_valid_i;
    assign ncase     = norm_case(low_ff, high_ff);
    assign sub       = (ncase == NORM_ABOVE) ? HALF_POINT :
                       (ncase == NORM_MIDDLE) ? QUARTER_POINT : 16'h0;
    assign offset    = 17'({1'b0, code_ff} - {1'b0, low_ff} + 17'h1);

    // -------------------------------------------------------------
    // shared divider: target count or span-times-frequency
    // -------------------------------------------------------------
    assign mul_f    = (state_ff == S_DIV_HI) ? f_hi_ff : f_lo_ff;
    assign divisor  = (state_ff == S_DEC_CUM) ? span_ff : {1'b0, total_ff};
    always_comb begin
        if (state_ff == S_DEC_CUM)
            dividend = 33'(offset * total_ff) - 33'h1;
        else
            dividend = 33'(span_ff * mul_f);
    end

    seq_divider u_div (
        .mclk_i     (mclk_i),
        .rst_n_i    (rst_n_i),
        .start_i    (div_start_ff),
        .dividend_i (dividend),
        .divisor_i  (divisor),
        .quot_o     (quot),
        .done_o     (div_done)
    );

    bit_run_emitter u_emit (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .start_i     (emit_start_ff),
        .first_bit_i (emit_first_ff),
        .count_i     (emit_cnt_ff),
        .ready_i     (enc_bit_ready_i),
        .bit_o       (enc_bit_o),
        .valid_o     (enc_bit_valid_o),
        .done_o      (emit_done)
    );

    // -------------------------------------------------------------
    // sequencer
    // -------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE: begin
                if (accept) begin
                    case (cmd_i)
                        CMD_ENC_SYMBOL: nxt_state = S_RD_TOTAL;
                        CMD_DEC_SYMBOL: nxt_state = S_RD_TOTAL;
                        CMD_ENC_FLUSH:  nxt_state = S_EMIT_WAIT;
                        CMD_DEC_INIT:   nxt_state = S_DEC_FILL;
                        default:        nxt_state = S_IDLE;
                    endcase
                end
            end
            S_RD_TOTAL:   nxt_state = is_dec_ff ? S_DEC_CUM : S_RD_HI;
            S_RD_HI:      nxt_state = S_RD_LO;
            S_RD_LO:      nxt_state = S_DIV_HI;
            S_DEC_CUM:    if (div_done) nxt_state = S_DEC_SEARCH;
            S_DEC_SEARCH: if (model_data_i <= cum_ff) nxt_state = S_DIV_HI;
            S_DIV_HI:     if (div_done) nxt_state = S_DIV_LO;
            S_DIV_LO: begin
                if (div_done)
                    nxt_state = is_dec_ff ? S_DEC_NORM : S_ENC_NORM;
            end
            S_ENC_NORM: begin
                if (ncase == NORM_NONE)
                    nxt_state = S_IDLE;
                else if (ncase != NORM_MIDDLE)
                    nxt_state = S_EMIT_WAIT;
            end
            S_EMIT_WAIT: if (emit_done) nxt_state = flush_ff ? S_IDLE : S_ENC_NORM;
            S_DEC_NORM:  nxt_state = (ncase == NORM_NONE) ? S_IDLE : S_DEC_BIT;
            S_DEC_BIT:   if (take) nxt_state = S_DEC_NORM;
            S_DEC_FILL:  if (take && fill_ff == 5'h1) nxt_state = S_IDLE;
            default:     nxt_state = S_IDLE;
        endcase
    end

    // state, status and result
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff     <= S_IDLE;
            busy_ff      <= 1'b0;
            done_ff      <= 1'b0;
            is_dec_ff    <= 1'b0;
            flush_ff     <= 1'b0;
            dec_index_ff <= 8'h0;
        end else begin
            state_ff <= nxt_state;
            busy_ff  <= (nxt_state != S_IDLE);
            done_ff  <= ((state_ff != S_IDLE) && (nxt_state == S_IDLE)) ||
                        (accept && cmd_i == CMD_ENC_START);
            if (accept) begin
                is_dec_ff <= (cmd_i == CMD_DEC_SYMBOL);
                flush_ff  <= (cmd_i == CMD_ENC_FLUSH);
            end
            if (state_ff == S_DEC_SEARCH && model_data_i <= cum_ff)
                dec_index_ff <= idx_ff - 8'h1;
        end
    end

    // -------------------------------------------------------------
    // interval, pending count and code window
    // -------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_ff     <= LOW_RESET;
            high_ff    <= TOP_VALUE;
            code_ff    <= CODE_RESET;
            pending_ff <= PENDING_RESET;
            span_ff    <= 17'h0;
        end else begin
            if (accept && (cmd_i == CMD_ENC_START || cmd_i == CMD_ENC_FLUSH)) begin
                low_ff     <= LOW_RESET;
                high_ff    <= TOP_VALUE;
                pending_ff <= PENDING_RESET;
            end
            if (accept && cmd_i == CMD_DEC_INIT) begin
                low_ff  <= LOW_RESET;
                high_ff <= TOP_VALUE;
                code_ff <= CODE_RESET;
            end
            if (state_ff == S_RD_TOTAL)
                span_ff <= 17'({1'b0, high_ff} - {1'b0, low_ff} + 17'h1);
            if (state_ff == S_DIV_HI && div_done)
                high_ff <= low_ff - 16'h1 + quot[15:0];
            if (state_ff == S_DIV_LO && div_done)
                low_ff <= low_ff + quot[15:0];
            if ((state_ff == S_ENC_NORM || state_ff == S_DEC_NORM) && ncase != NORM_NONE) begin
                low_ff  <= sub_shl(low_ff, sub);
                high_ff <= sub_shl(high_ff, sub) | 16'h1;
            end
            if (state_ff == S_ENC_NORM && ncase == NORM_MIDDLE)
                pending_ff <= pending_ff + 16'h1;
            if (state_ff == S_ENC_NORM && (ncase == NORM_BELOW || ncase == NORM_ABOVE))
                pending_ff <= PENDING_RESET;
            if (state_ff == S_DEC_NORM && ncase != NORM_NONE)
                code_ff <= sub_shl(code_ff, sub);
            if (state_ff == S_DEC_BIT && take)
                code_ff <= {code_ff[15:1], dec_bit_i};
            if (state_ff == S_DEC_FILL && take)
                code_ff <= {code_ff[14:0], dec_bit_i};
        end
    end

    // -------------------------------------------------------------
    // model reads and search
    // -------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_ff  <= 8'h0;
            idx_ff   <= 8'h0;
            total_ff <= 16'h0;
            f_hi_ff  <= 16'h0;
            f_lo_ff  <= 16'h0;
            prev_ff  <= 16'h0;
            cum_ff   <= 16'h0;
        end else begin
            case (state_ff)
                S_IDLE: begin
                    if (accept) begin
                        addr_ff <= 8'h0;
                        idx_ff  <= index_i;
                    end
                end
                S_RD_TOTAL: begin
                    total_ff <= model_data_i;
                    addr_ff  <= idx_ff;
                end
                S_RD_HI: begin
                    f_hi_ff <= model_data_i;
                    addr_ff <= idx_ff + 8'h1;
                end
                S_RD_LO: f_lo_ff <= model_data_i;
                S_DEC_CUM: begin
                    if (div_done) begin
                        cum_ff  <= quot[15:0];
                        addr_ff <= 8'h1;
                        idx_ff  <= 8'h1;
                        prev_ff <= total_ff;
                    end
                end
                S_DEC_SEARCH: begin
                    if (model_data_i <= cum_ff) begin
                        f_hi_ff <= prev_ff;
                        f_lo_ff <= model_data_i;
                    end else begin
                        prev_ff <= model_data_i;
                        idx_ff  <= idx_ff + 8'h1;
                        addr_ff <= idx_ff + 8'h1;
                    end
                end
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------
    // divider, emitter and bit-fetch handshakes
    // -------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_start_ff  <= 1'b0;
            emit_start_ff <= 1'b0;
            emit_first_ff <= 1'b0;
            emit_cnt_ff   <= 16'h0;
            ready_ff      <= 1'b0;
            fill_ff       <= 5'h0;
        end else begin
            div_start_ff  <= (nxt_state != state_ff) && (nxt_state == S_DEC_CUM ||
                             nxt_state == S_DIV_HI || nxt_state == S_DIV_LO);
            emit_start_ff <= 1'b0;
            ready_ff      <= (nxt_state == S_DEC_BIT) || (nxt_state == S_DEC_FILL);
            if (state_ff == S_ENC_NORM && (ncase == NORM_BELOW || ncase == NORM_ABOVE)) begin
                emit_start_ff <= 1'b1;
                emit_first_ff <= (ncase == NORM_ABOVE);
                emit_cnt_ff   <= pending_ff;
            end
            if (accept && cmd_i == CMD_ENC_FLUSH) begin
                emit_start_ff <= 1'b1;
                emit_first_ff <= (low_ff >= QUARTER_POINT);
                emit_cnt_ff   <= pending_ff + 16'h1;
            end
            if (accept && cmd_i == CMD_DEC_INIT)
                fill_ff <= INIT_BITS;
            else if (state_ff == S_DEC_FILL && take)
                fill_ff <= fill_ff - 5'h1;
        end
    end

    assign model_addr_o    = addr_ff;
    assign dec_bit_ready_o = ready_ff;
    assign dec_index_o     = dec_index_ff;
    assign busy_o          = busy_ff;
    assign done_o          = done_ff;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    chk_session_load: assert property (
        accept && cmd_i == CMD_ENC_START |=> low_ff == LOW_RESET && high_ff == TOP_VALUE
        && pending_ff == PENDING_RESET) else $error("session start did not load interval");
    chk_span_value: assert property (
        state_ff == S_RD_TOTAL |=> span_ff == 17'({1'b0, $past(high_ff)}
        - {1'b0, $past(low_ff)} + 17'h1)) else $error("span wrong");
    chk_emit_zero: assert property (
        state_ff == S_ENC_NORM && ncase == NORM_BELOW |=> emit_start_ff && !emit_first_ff
        && emit_cnt_ff == $past(pending_ff) ##1 enc_bit_valid_o && !enc_bit_o)
        else $error("low half did not emit zero");
    chk_emit_one: assert property (
        state_ff == S_ENC_NORM && ncase == NORM_ABOVE |=> emit_first_ff
        && low_ff == sub_shl($past(low_ff), HALF_POINT)) else $error("upper half wrong");
    chk_bit_hold: assert property (
        enc_bit_valid_o && !enc_bit_ready_i |=> enc_bit_valid_o && $stable(enc_bit_o))
        else $error("coded bit dropped before taken");
    chk_search_stop: assert property (
        state_ff == S_DEC_SEARCH && model_data_i <= cum_ff |=> state_ff == S_DIV_HI
        && dec_index_ff == $past(idx_ff) - 8'h1) else $error("search stop wrong");
    chk_dec_half: assert property (
        state_ff == S_DEC_NORM && ncase == NORM_ABOVE |=>
        code_ff == sub_shl($past(code_ff), HALF_POINT)) else $error("half window wrong");
    chk_dec_quarter: assert property (
        state_ff == S_DEC_NORM && ncase == NORM_MIDDLE |=>
        low_ff == sub_shl($past(low_ff), QUARTER_POINT)) else $error("quarter wrong");
    chk_dec_shift: assert property (
        state_ff == S_DEC_NORM && ncase != NORM_NONE |=> high_ff[0] && dec_bit_ready_o)
        else $error("renorm did not fetch bit");
    chk_fill_msb: assert property (
        state_ff == S_DEC_FILL && take |=> code_ff[0] == $past(dec_bit_i)
        && code_ff[15:1] == $past(code_ff[14:0])) else $error("fill order wrong");
    chk_flush_reset: assert property (
        accept && cmd_i == CMD_ENC_FLUSH |=> high_ff == TOP_VALUE && low_ff == LOW_RESET
        && emit_cnt_ff == $past(pending_ff) + 16'h1) else $error("flush wrong");
    chk_mode_gate: assert property (
        state_ff == S_IDLE && !syntax_arith_coding_mode_i |=> state_ff == S_IDLE)
        else $error("command taken with mode off");

    cov_enc_symbol: cover property (state_ff == S_EMIT_WAIT ##[1:40] emit_done);
    cov_dec_symbol: cover property (state_ff == S_DEC_NORM ##1 state_ff == S_IDLE);
    cov_middle:     cover property (state_ff == S_ENC_NORM && ncase == NORM_MIDDLE);
    cov_init_done:  cover property (state_ff == S_DEC_FILL ##1 state_ff == S_IDLE);
endmodule

/* bench/arith_far_side.sv */
// far-side model: cumulative model store and both coded-bit fifos
`timescale 1ns/1ns
module arith_far_side #(
    parameter logic [31:0] SRC = 32'h9400_0600
) (
    input  wire logic        mclk_i,
    input  wire logic        wide_i,
    input  wire logic [7:0]  addr_i,
    output logic      [15:0] data_o,
    input  wire logic        bit_i,
    input  wire logic        bit_valid_i,
    output logic             bit_ready_o,
    output logic             src_bit_o,
    output logic             src_valid_o,
    input  wire logic        src_ready_i
);
    logic [15:0] got_ff = 16'h0000;
    int          got_n = 0;
    int          ptr = 0;
    logic        stall_ff = 1'b0;
    // model {2,1,0}, or {3,2,1,0} when wide: first entry holds the total
    assign data_o = wide_i ? 16'(addr_i < 8'h03 ? 8'h03 - addr_i : 8'h00) :
                    (addr_i == 8'h00) ? 16'h0002 : {15'h0000, addr_i == 8'h01};
    // both fifos stall on every other cycle
    assign bit_ready_o = stall_ff;
    assign src_valid_o = stall_ff;
    // idle data line shows the inverse of the next bit
    assign src_bit_o = SRC[31 - (ptr % 32)] ^ ~stall_ff;
    // collect coded bits in order, hand out source bits one at a time
    always @(posedge mclk_i) begin
        if (bit_valid_i && bit_ready_o) begin
            got_ff <= {got_ff[14:0], bit_i};
            got_n <= got_n + 1;
        end
        if (src_valid_o && src_ready_i) ptr <= ptr + 1;
        stall_ff <= ~stall_ff;
    end
endmodule

/* bench/test_arith_symbol_coder.sv */
// self-checking testbench for the arithmetic symbol coder
`timescale 1ns/1ns
module test_arith_symbol_coder;
    import arith_pkg::*;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, mode = 1'b1, cv = 1'b0, wide = 1'b0;
    cmd_t cmd = CMD_ENC_START;
    logic [7:0] idx = 8'h00, addr, dec_idx;
    logic [15:0] mdata;
    logic eb, ebv, ebr, db, dbv, dbr, busy, done;
    int failures = 0, num_checks = 0;
    always #2 mclk_i = ~mclk_i;
    arith_symbol_coder arith_symbol_coder_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .syntax_arith_coding_mode_i(mode), .cmd_valid_i(cv), .cmd_i(cmd), .index_i(idx),
        .model_addr_o(addr), .model_data_i(mdata), .enc_bit_o(eb), .enc_bit_valid_o(ebv),
        .enc_bit_ready_i(ebr), .dec_bit_i(db), .dec_bit_valid_i(dbv), .dec_bit_ready_o(dbr),
        .dec_index_o(dec_idx), .busy_o(busy), .done_o(done));
    arith_far_side arith_far_side_inst (.mclk_i(mclk_i), .addr_i(addr), .data_o(mdata),
        .wide_i(wide), .bit_i(eb), .bit_valid_i(ebv), .bit_ready_o(ebr), .src_bit_o(db),
        .src_valid_o(dbv), .src_ready_i(dbr));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // issue one command and wait for its done pulse
    task automatic run_cmd(input cmd_t c, input logic [7:0] i);
        int n;
        @(negedge mclk_i);
        cv = 1'b1;
        cmd = c;
        idx = i;
        @(negedge mclk_i);
        cv = 1'b0;
        for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge mclk_i);
        check({15'h0000, done}, 16'h0001);
    endtask
    // a command with the mode low is ignored
    task automatic test_refused;
        mode = 1'b0;
        cmd = CMD_DEC_INIT;
        @(negedge mclk_i);
        cv = 1'b1;
        @(negedge mclk_i);
        cv = 1'b0;
        repeat (3) @(negedge mclk_i);
        check({15'h0000, busy}, 16'h0000);
        check(16'(arith_far_side_inst.ptr), 16'h0000);
        mode = 1'b1;
        $display("refused test done");
    endtask
    // symbols 0,1,1,0 then flush give bits 100101
    task automatic test_encode;
        run_cmd(CMD_ENC_START, 8'h00);
        for (int k = 0; k < 4; k++) run_cmd(CMD_ENC_SYMBOL, {7'h00, k == 1 || k == 2});
        check(16'(arith_far_side_inst.got_n), 16'h0004);
        check(arith_far_side_inst.got_ff, 16'h0009);
        run_cmd(CMD_ENC_FLUSH, 8'h00);
        check(16'(arith_far_side_inst.got_n), 16'h0006);
        check(arith_far_side_inst.got_ff, 16'h0025);
        $display("encode test done");
    endtask
    // decode the same bits back, one fetch per symbol
    task automatic test_decode;
        run_cmd(CMD_DEC_INIT, 8'h00);
        check(16'(arith_far_side_inst.ptr), 16'h0010);
        for (int k = 0; k < 4; k++) begin
            run_cmd(CMD_DEC_SYMBOL, 8'h00);
            check({8'h00, dec_idx}, {15'h0000, k == 1 || k == 2});
        end
        check(16'(arith_far_side_inst.ptr), 16'h0014);
        $display("decode test done");
    endtask
    // three-way model: middle case defers a bit, then decode it back
    task automatic test_middle;
        wide = 1'b1;
        run_cmd(CMD_ENC_START, 8'h00);
        run_cmd(CMD_ENC_SYMBOL, 8'h01);
        check(16'(arith_far_side_inst.got_n), 16'h0006);
        run_cmd(CMD_ENC_FLUSH, 8'h00);
        check(16'(arith_far_side_inst.got_n), 16'h0009);
        check(arith_far_side_inst.got_ff, 16'h012B);
        run_cmd(CMD_DEC_INIT, 8'h00);
        run_cmd(CMD_DEC_SYMBOL, 8'h00);
        check({8'h00, dec_idx}, 16'h0001);
        check(16'(arith_far_side_inst.ptr), 16'h0025);
        wide = 1'b0;
        $display("middle test done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge mclk_i);
        rst_n_i = 1'b1;
        test_refused();
        test_encode();
        test_decode();
        test_middle();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        failures++;
        give_verdict();
    end
endmodule
